// [logic/pbd_pkg.sv]
// constants and types shared by the peripheral base decoder
package pbd_pkg;

    // control register space codes of the two base registers
    localparam logic [11:0] CREG_PRIMARY = 12'hC0F;
    localparam logic [11:0] CREG_SECONDARY = 12'hC0E;

    // base register field positions
    localparam int VALID_BIT = 0;
    localparam int USER_DATA_BIT = 1;
    localparam int USER_CODE_BIT = 2;
    localparam int SUP_DATA_BIT = 3;
    localparam int SUP_CODE_BIT = 4;
    localparam int CPU_SPACE_BIT = 5;
    localparam int ALT_MASTER_BIT = 6;
    localparam int WRITE_PROT_BIT = 8;
    localparam int PRI_BASE_LSB = 12;
    localparam int SEC_BASE_LSB = 30;

    // bits that hold state; the rest read as zero
    localparam logic [31:0] PRI_WR_MASK = 32'hFFFF_F17F;
    localparam logic [31:0] SEC_WR_MASK = 32'hC000_00FF;

    // value of the valid bits after reset
    localparam logic VALID_RESET = 1'h0;

    // primary window offsets
    localparam logic [11:0] OFS_SYS_CTRL = 12'h000;
    localparam logic [11:0] OFS_BUS_PARK = 12'h00C;
    localparam logic [11:0] OFS_IRQ_PEND = 12'h040;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h044;
    localparam logic [11:0] OFS_IRQ_CTRL_FIRST = 12'h04C;
    localparam logic [11:0] OFS_IRQ_CTRL_LAST = 12'h057;
    localparam logic [11:0] OFS_DEVICE_ID = 12'h0AC;

    // secondary window offsets
    localparam logic [11:0] OFS_GPIO_LO = 12'h000;
    localparam logic [11:0] OFS_GPIO_HI = 12'h0B0;
    localparam logic [11:0] OFS_SEC_PRIO_FIRST = 12'h140;
    localparam logic [11:0] OFS_SEC_PRIO_LAST = 12'h15C;
    localparam logic [11:0] OFS_SPUR_VEC = 12'h164;
    localparam logic [11:0] OFS_VEC_BASE = 12'h168;
    localparam logic [11:0] OFS_SOFT_IRQ = 12'h198;

    // where an access is routed
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_SRAM,
        TGT_PRIMARY,
        TGT_SECONDARY,
        TGT_EXTERNAL
    } pbd_target_t;

    // register addressed inside a window
    typedef enum logic [4:0] {
        REG_NONE,
        REG_RESET_CAUSE,
        REG_SYS_PROTECT,
        REG_WDOG_VECTOR,
        REG_WDOG_SERVICE,
        REG_BUS_PARK,
        REG_IRQ_PENDING,
        REG_IRQ_MASK,
        REG_IRQ_CTRL,
        REG_DEVICE_ID,
        REG_GPIO_LO_IN,
        REG_GPIO_LO_OUT,
        REG_GPIO_LO_OE,
        REG_GPIO_LO_FUNC,
        REG_GPIO_HI_IN,
        REG_GPIO_HI_OUT,
        REG_GPIO_HI_OE,
        REG_GPIO_HI_FUNC,
        REG_SEC_PRIORITY,
        REG_SPUR_VECTOR,
        REG_VECTOR_BASE,
        REG_SOFT_IRQ
    } pbd_reg_t;

    typedef struct packed {
        pbd_reg_t id;
        logic [3:0] idx;
        logic readOnly;
    } pbd_regsel_t;

endpackage

// [logic/pbd_base_if.sv]
// base register contents passed from the store to the window compare
`timescale 1ns/1ns
interface pbd_base_if;
    logic [31:0] primaryBase;
    logic [31:0] secondaryBase;

    modport store (
        output primaryBase,
        output secondaryBase
    );

    modport match (
        input primaryBase,
        input secondaryBase
    );
endinterface

// [logic/pbd_base_store.sv]
// the two base registers with their control-register and debug ports
`timescale 1ns/1ns
module pbd_base_store (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control register writes
    input wire logic cregWrEn,
    input wire logic [11:0] cregSel,
    input wire logic [31:0] cregWrData,
    input wire logic cregSuper,
    // debug read
    input wire logic dbgRdEn,
    input wire logic [11:0] dbgRdSel,
    output logic [31:0] dbgRdData,
    output logic dbgRdValid,
    // stored values
    pbd_base_if.store base
);
    logic priValid;
    logic secValid;
    logic [31:1] priBody;
    logic [31:1] secBody;

    // only supervisor control register writes reach the store
    wire priWr = cregWrEn && cregSuper && cregSel == pbd_pkg::CREG_PRIMARY;
    wire secWr = cregWrEn && cregSuper
        && cregSel == pbd_pkg::CREG_SECONDARY;
    wire [31:0] priMasked = cregWrData & pbd_pkg::PRI_WR_MASK;
    wire [31:0] secMasked = cregWrData & pbd_pkg::SEC_WR_MASK;
    wire [31:0] dbgSelData =
        dbgRdSel == pbd_pkg::CREG_PRIMARY ? base.primaryBase :
        dbgRdSel == pbd_pkg::CREG_SECONDARY ? base.secondaryBase :
        32'h0000_0000;

    assign base.primaryBase = {priBody, priValid};
    assign base.secondaryBase = {secBody, secValid};

    // valid bits alone are reset
    always_ff @(posedge clk) begin
        if (srst) begin
            priValid <= pbd_pkg::VALID_RESET;
            secValid <= pbd_pkg::VALID_RESET;
        end else begin
            if (priWr) begin
                priValid <= cregWrData[pbd_pkg::VALID_BIT];
            end
            if (secWr) begin
                secValid <= cregWrData[pbd_pkg::VALID_BIT];
            end
        end
    end

    // address and mask bits keep no reset value
    always_ff @(posedge clk) begin
        if (priWr) begin
            priBody <= priMasked[31:1];
        end
        if (secWr) begin
            secBody <= secMasked[31:1];
        end
    end

    // read-back exists only on the debug port
    always_ff @(posedge clk) begin
        if (srst) begin
            dbgRdData <= 32'h0000_0000;
            dbgRdValid <= 1'h0;
        end else begin
            dbgRdValid <= dbgRdEn;
            if (dbgRdEn) begin
                dbgRdData <= dbgSelData;
            end
        end
    end
endmodule

// [logic/pbd_window_match.sv]
// compares one access against the primary and secondary windows
`timescale 1ns/1ns
module pbd_window_match (
    // access attributes
    input wire logic [31:0] accAddr,
    input wire logic accSuper,
    input wire logic accCode,
    input wire logic accIack,
    input wire logic accAltMaster,
    // base registers
    pbd_base_if.match base,
    // results
    output logic primaryHit,
    output logic secondaryHit,
    output logic primaryWrProt
);
    wire [31:0] pb = base.primaryBase;
    wire [31:0] sb = base.secondaryBase;

    // space mask picked by supervisor and code attributes
    wire spaceMask = accSuper
        ? (accCode ? pb[pbd_pkg::SUP_CODE_BIT] : pb[pbd_pkg::SUP_DATA_BIT])
        : (accCode ? pb[pbd_pkg::USER_CODE_BIT]
                   : pb[pbd_pkg::USER_DATA_BIT]);

    // acknowledge cycles obey only their own mask
    // an alternate master skips the space masks
    wire priMasked = accIack ? pb[pbd_pkg::CPU_SPACE_BIT]
        : accAltMaster ? pb[pbd_pkg::ALT_MASTER_BIT]
        : spaceMask;

    wire priAddrEq = accAddr[31:pbd_pkg::PRI_BASE_LSB]
        == pb[31:pbd_pkg::PRI_BASE_LSB];
    wire secAddrEq = accAddr[31:pbd_pkg::SEC_BASE_LSB]
        == sb[31:pbd_pkg::SEC_BASE_LSB];

    assign primaryHit = pb[pbd_pkg::VALID_BIT] && priAddrEq
        && !priMasked;
    assign secondaryHit = sb[pbd_pkg::VALID_BIT] && secAddrEq;
    assign primaryWrProt = pb[pbd_pkg::WRITE_PROT_BIT];
endmodule

// [logic/pbd_peripheral_base_decoder.sv]
// peripheral base decoder: windows, routing and register offsets
`timescale 1ns/1ns
module pbd_peripheral_base_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control register writes from the core
    input wire logic cregWrEn,
    input wire logic [11:0] cregSel,
    input wire logic [31:0] cregWrData,
    input wire logic cregSuper,
    // background debug read-back
    input wire logic dbgRdEn,
    input wire logic [11:0] dbgRdSel,
    output logic [31:0] dbgRdData,
    output logic dbgRdValid,
    // processor bus access
    input wire logic accValid,
    input wire logic [31:0] accAddr,
    input wire logic accWrite,
    input wire logic accSuper,
    input wire logic accCode,
    input wire logic accIack,
    input wire logic accAltMaster,
    input wire logic sramHit,
    // decode result, one cycle after the access
    output logic decValid,
    output pbd_pkg::pbd_target_t decTarget,
    output pbd_pkg::pbd_reg_t decReg,
    output logic [3:0] decIndex,
    output logic [1:0] decLane,
    output logic [11:0] decOffset,
    output logic decWrEn,
    output logic decWrBlocked
);
    pbd_base_if base ();

    logic primaryHit;
    logic secondaryHit;
    logic primaryWrProt;

    pbd_base_store u_store (
        .clk(clk),
        .srst(srst),
        .cregWrEn(cregWrEn),
        .cregSel(cregSel),
        .cregWrData(cregWrData),
        .cregSuper(cregSuper),
        .dbgRdEn(dbgRdEn),
        .dbgRdSel(dbgRdSel),
        .dbgRdData(dbgRdData),
        .dbgRdValid(dbgRdValid),
        .base(base.store)
    );

    pbd_window_match u_match (
        .accAddr(accAddr),
        .accSuper(accSuper),
        .accCode(accCode),
        .accIack(accIack),
        .accAltMaster(accAltMaster),
        .base(base.match),
        .primaryHit(primaryHit),
        .primaryWrProt(primaryWrProt),
        .secondaryHit(secondaryHit)
    );

    // builds one register selection
    function automatic pbd_pkg::pbd_regsel_t regSel(
        input pbd_pkg::pbd_reg_t id,
        input logic [3:0] idx,
        input logic readOnly
    );
        pbd_pkg::pbd_regsel_t s;
        s.id = id;
        s.idx = idx;
        s.readOnly = readOnly;
        return s;
    endfunction

    // selects one of the four registers of a gpio bank
    function automatic pbd_pkg::pbd_regsel_t gpioSel(
        input logic [1:0] word,
        input logic high
    );
        pbd_pkg::pbd_regsel_t s;
        s = regSel(pbd_pkg::REG_NONE, 4'h0, 1'h0);
        unique case (word)
            2'h0: begin
                s = regSel(high ? pbd_pkg::REG_GPIO_HI_IN
                    : pbd_pkg::REG_GPIO_LO_IN, 4'h0, 1'h1);
            end
            2'h1: begin
                s = regSel(high ? pbd_pkg::REG_GPIO_HI_OUT
                    : pbd_pkg::REG_GPIO_LO_OUT, 4'h0, 1'h0);
            end
            2'h2: begin
                s = regSel(high ? pbd_pkg::REG_GPIO_HI_OE
                    : pbd_pkg::REG_GPIO_LO_OE, 4'h0, 1'h0);
            end
            2'h3: begin
                s = regSel(high ? pbd_pkg::REG_GPIO_HI_FUNC
                    : pbd_pkg::REG_GPIO_LO_FUNC, 4'h0, 1'h0);
            end
        endcase
        return s;
    endfunction

    // primary window offsets; reserved words give REG_NONE
    function automatic pbd_pkg::pbd_regsel_t primarySel(
        input logic [11:0] ofs
    );
        pbd_pkg::pbd_regsel_t s;
        logic [11:0] ctrlOfs;
        s = regSel(pbd_pkg::REG_NONE, 4'h0, 1'h0);
        ctrlOfs = ofs - pbd_pkg::OFS_IRQ_CTRL_FIRST;
        if (ofs[11:2] == pbd_pkg::OFS_SYS_CTRL[11:2]) begin
            unique case (ofs[1:0])
                2'h0: s = regSel(pbd_pkg::REG_RESET_CAUSE, 4'h0, 1'h0);
                2'h1: s = regSel(pbd_pkg::REG_SYS_PROTECT, 4'h0, 1'h0);
                2'h2: s = regSel(pbd_pkg::REG_WDOG_VECTOR, 4'h0, 1'h0);
                2'h3: s = regSel(pbd_pkg::REG_WDOG_SERVICE, 4'h0, 1'h0);
            endcase
        end else if (ofs == pbd_pkg::OFS_BUS_PARK) begin
            s = regSel(pbd_pkg::REG_BUS_PARK, 4'h0, 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_IRQ_PEND[11:2]) begin
            s = regSel(pbd_pkg::REG_IRQ_PENDING, 4'h0, 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_IRQ_MASK[11:2]) begin
            s = regSel(pbd_pkg::REG_IRQ_MASK, 4'h0, 1'h0);
        end else if (ofs >= pbd_pkg::OFS_IRQ_CTRL_FIRST
                && ofs <= pbd_pkg::OFS_IRQ_CTRL_LAST) begin
            // byte offset from the first control word is the index
            s = regSel(pbd_pkg::REG_IRQ_CTRL, ctrlOfs[3:0], 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_DEVICE_ID[11:2]) begin
            s = regSel(pbd_pkg::REG_DEVICE_ID, 4'h0, 1'h1);
        end
        return s;
    endfunction

    // secondary window offsets; only the low 4 KB holds registers
    function automatic pbd_pkg::pbd_regsel_t secondarySel(
        input logic [29:0] ofsFull
    );
        pbd_pkg::pbd_regsel_t s;
        logic [11:0] ofs;
        logic [11:0] prioOfs;
        s = regSel(pbd_pkg::REG_NONE, 4'h0, 1'h0);
        ofs = ofsFull[11:0];
        prioOfs = ofs - pbd_pkg::OFS_SEC_PRIO_FIRST;
        if (ofsFull[29:12] != 18'h0_0000) begin
            s = regSel(pbd_pkg::REG_NONE, 4'h0, 1'h0);
        end else if (ofs[11:4] == pbd_pkg::OFS_GPIO_LO[11:4]) begin
            s = gpioSel(ofs[3:2], 1'h0);
        end else if (ofs[11:4] == pbd_pkg::OFS_GPIO_HI[11:4]) begin
            s = gpioSel(ofs[3:2], 1'h1);
        end else if (ofs >= pbd_pkg::OFS_SEC_PRIO_FIRST
                && ofs[11:2] <= pbd_pkg::OFS_SEC_PRIO_LAST[11:2]) begin
            // one word per group of eight sources
            s = regSel(pbd_pkg::REG_SEC_PRIORITY,
                {1'h0, prioOfs[4:2]}, 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_SPUR_VEC[11:2]) begin
            s = regSel(pbd_pkg::REG_SPUR_VECTOR, 4'h0, 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_VEC_BASE[11:2]) begin
            s = regSel(pbd_pkg::REG_VECTOR_BASE, 4'h0, 1'h0);
        end else if (ofs[11:2] == pbd_pkg::OFS_SOFT_IRQ[11:2]) begin
            s = regSel(pbd_pkg::REG_SOFT_IRQ, 4'h0, 1'h0);
        end
        return s;
    endfunction

    // routing in fixed priority
    wire pbd_pkg::pbd_target_t routeTarget =
        !accValid ? pbd_pkg::TGT_NONE :
        sramHit ? pbd_pkg::TGT_SRAM :
        primaryHit ? pbd_pkg::TGT_PRIMARY :
        secondaryHit ? pbd_pkg::TGT_SECONDARY :
        pbd_pkg::TGT_EXTERNAL;

    wire pbd_pkg::pbd_regsel_t priSel = primarySel(accAddr[11:0]);
    wire pbd_pkg::pbd_regsel_t secSel = secondarySel(accAddr[29:0]);

    wire isPrimary = routeTarget == pbd_pkg::TGT_PRIMARY;
    wire isSecondary = routeTarget == pbd_pkg::TGT_SECONDARY;

    wire pbd_pkg::pbd_regsel_t pickSel =
        isPrimary ? priSel :
        isSecondary ? secSel :
        regSel(pbd_pkg::REG_NONE, 4'h0, 1'h0);

    // protected window or read-only register swallows the write
    wire primaryBlock = isPrimary && primaryWrProt;
    wire roBlock = (isPrimary || isSecondary) && pickSel.readOnly;

    wire next_decWrBlocked = accWrite && (primaryBlock || roBlock);
    wire next_decWrEn = accWrite && (isPrimary || isSecondary)
        && pickSel.id != pbd_pkg::REG_NONE && !next_decWrBlocked;

    // decode registered so every result leaves from a flip-flop
    always_ff @(posedge clk) begin
        if (srst) begin
            decValid <= 1'h0;
            decTarget <= pbd_pkg::TGT_NONE;
            decReg <= pbd_pkg::REG_NONE;
            decIndex <= 4'h0;
            decLane <= 2'h0;
            decOffset <= 12'h000;
            decWrEn <= 1'h0;
            decWrBlocked <= 1'h0;
        end else begin
            decValid <= accValid;
            decTarget <= routeTarget;
            decReg <= pickSel.id;
            decIndex <= pickSel.idx;
            decLane <= accAddr[1:0];
            decOffset <= accAddr[11:0];
            decWrEn <= next_decWrEn;
            decWrBlocked <= next_decWrBlocked;
        end
    end
endmodule

// [bench/pbd_peripheral_base_decoder_chk.sv]
// port-level assertions for the peripheral base decoder
`timescale 1ns/1ns
module pbd_peripheral_base_decoder_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control register writes and debug reads
    input wire logic cregWrEn,
    input wire logic [11:0] cregSel,
    input wire logic [31:0] cregWrData,
    input wire logic cregSuper,
    input wire logic dbgRdEn,
    input wire logic [11:0] dbgRdSel,
    input wire logic [31:0] dbgRdData,
    input wire logic dbgRdValid,
    // bus access
    input wire logic accValid,
    input wire logic [31:0] accAddr,
    input wire logic accWrite,
    input wire logic accSuper,
    input wire logic accCode,
    input wire logic accIack,
    input wire logic accAltMaster,
    input wire logic sramHit,
    // decode result
    input wire logic decValid,
    input wire pbd_pkg::pbd_target_t decTarget,
    input wire pbd_pkg::pbd_reg_t decReg,
    input wire logic [3:0] decIndex,
    input wire logic [1:0] decLane,
    input wire logic [11:0] decOffset,
    input wire logic decWrEn,
    input wire logic decWrBlocked
);
    logic [31:0] pri;
    logic [31:0] sec;
    wire priWr = cregWrEn & cregSuper & (cregSel == pbd_pkg::CREG_PRIMARY);
    wire secWr = cregWrEn & cregSuper & (cregSel == pbd_pkg::CREG_SECONDARY);
    wire spaceMask = accSuper ? (accCode ? pri[4] : pri[3])
        : (accCode ? pri[2] : pri[1]);
    wire priMask = accIack ? pri[5] : (accAltMaster ? pri[6] : spaceMask);
    wire priHit = pri[0] & (accAddr[31:12] == pri[31:12]) & ~priMask;
    wire secHit = sec[0] & (accAddr[31:30] == sec[31:30]);
    wire fresh = accValid & ~sramHit;

    // shadow of the base registers; only the valid bits are known after reset
    always_ff @(posedge clk) begin
        if (priWr) pri <= cregWrData;
        if (secWr) sec <= cregWrData;
        if (srst) begin
            pri[0] <= 1'b0;
            sec[0] <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence priRead;
        dbgRdEn && dbgRdSel == pbd_pkg::CREG_PRIMARY;
    endsequence

    valid_follow_a: assert property (decValid == $past(accValid))
        else $error("decode valid does not follow access");
    sram_first_a: assert property (accValid && sramHit |=>
        decTarget == pbd_pkg::TGT_SRAM) else $error("sram not first");
    primary_hit_a: assert property (fresh && priHit |=>
        decTarget == pbd_pkg::TGT_PRIMARY) else $error("primary hit lost");
    secondary_hit_a: assert property (fresh && !priHit && secHit |=>
        decTarget == pbd_pkg::TGT_SECONDARY) else $error("secondary hit lost");
    miss_external_a: assert property (
        fresh && !priHit && !secHit |=>
        decTarget == pbd_pkg::TGT_EXTERNAL) else $error("miss not external");
    write_prot_a: assert property (
        fresh && accWrite && priHit && pri[8] |=>
        decWrBlocked && !decWrEn) else $error("protected write passed");
    lane_offset_a: assert property (accValid |=>
        decLane == $past(accAddr[1:0])
        && decOffset == $past(accAddr[11:0])) else $error("lane or offset");
    debug_answer_a: assert property (dbgRdEn |=> dbgRdValid)
        else $error("debug read not answered");
    debug_quiet_a: assert property (!dbgRdEn |=> !dbgRdValid)
        else $error("debug valid without read");
    debug_data_a: assert property (priRead |=>
        dbgRdData == ($past(pri) & pbd_pkg::PRI_WR_MASK))
        else $error("debug read data wrong");
    wr_exclusive_a: assert property (decWrEn |->
        !decWrBlocked && $past(accValid) && $past(accWrite))
        else $error("write enable wrong");
endmodule

bind pbd_peripheral_base_decoder pbd_peripheral_base_decoder_chk chk_u (
    .clk, .srst, .cregWrEn, .cregSel, .cregWrData, .cregSuper, .dbgRdEn,
    .dbgRdSel, .dbgRdData, .dbgRdValid, .accValid, .accAddr, .accWrite,
    .accSuper, .accCode, .accIack, .accAltMaster, .sramHit, .decValid,
    .decTarget, .decReg, .decIndex, .decLane, .decOffset, .decWrEn,
    .decWrBlocked
);

// [bench/pbd_core_model.sv]
// processor core model: control writes, debug reads and bus accesses
`timescale 1ns/1ns
module pbd_core_model (
    // clock
    input wire logic clk,
    // control register writes
    output logic cregWrEn,
    output logic [11:0] cregSel,
    output logic [31:0] cregWrData,
    output logic cregSuper,
    // debug read
    output logic dbgRdEn,
    output logic [11:0] dbgRdSel,
    // bus access
    output logic accValid,
    output logic [31:0] accAddr,
    output logic [5:0] accAttr
);
    initial begin
        {cregWrEn, cregSuper, dbgRdEn, accValid} = 4'h0;
        {cregSel, dbgRdSel} = 24'h0;
        {cregWrData, accAddr} = 64'h0;
        accAttr = 6'h0;
    end

    // control space write; the supervisor flag decides whether it lands
    task automatic creg_write(input logic [11:0] sel, input logic [31:0] d,
            input logic sup);
        @(negedge clk);
        cregWrEn = 1'b1;
        cregSel = sel;
        cregWrData = d;
        cregSuper = sup;
        @(negedge clk);
        cregWrEn = 1'b0;
        cregWrData = ~cregWrData;
    endtask

    task automatic dbg_read(input logic [11:0] sel);
        @(negedge clk);
        dbgRdEn = 1'b1;
        dbgRdSel = sel;
        @(negedge clk);
        dbgRdEn = 1'b0;
    endtask

    // attr is {write, super, code, iack, alternate, sram}
    task automatic acc(input logic [31:0] a, input logic [5:0] at);
        @(negedge clk);
        accValid = 1'b1;
        accAddr = a;
        accAttr = at;
        @(negedge clk);
        accValid = 1'b0;
        // released bus must not look like the last address
        accAddr = ~accAddr;
    endtask
endmodule

// [bench/pbd_peripheral_base_decoder_test.sv]
// self-checking bench for the peripheral base decoder
`timescale 1ns/1ns
module pbd_peripheral_base_decoder_test;
    localparam logic [31:0] PRI = 32'h1000_0000;
    localparam logic [31:0] SEC = 32'h8000_0000;
    localparam logic [5:0] RD_SUP = 6'h10;
    localparam pbd_pkg::pbd_target_t EXT = pbd_pkg::TGT_EXTERNAL;
    localparam pbd_pkg::pbd_target_t PRIM = pbd_pkg::TGT_PRIMARY;
    localparam pbd_pkg::pbd_target_t SECN = pbd_pkg::TGT_SECONDARY;
    localparam pbd_pkg::pbd_reg_t NOREG = pbd_pkg::REG_NONE;
    localparam pbd_pkg::pbd_reg_t RC = pbd_pkg::REG_RESET_CAUSE;
    localparam logic [11:0] POFS [12] = '{12'h000, 12'h001, 12'h002, 12'h003,
        12'h004, 12'h00C, 12'h00D, 12'h040, 12'h044, 12'h04C, 12'h057,
        12'h0AC};
    localparam pbd_pkg::pbd_reg_t PREG [12] = '{RC, pbd_pkg::REG_SYS_PROTECT,
        pbd_pkg::REG_WDOG_VECTOR, pbd_pkg::REG_WDOG_SERVICE, NOREG,
        pbd_pkg::REG_BUS_PARK, NOREG, pbd_pkg::REG_IRQ_PENDING,
        pbd_pkg::REG_IRQ_MASK, pbd_pkg::REG_IRQ_CTRL, pbd_pkg::REG_IRQ_CTRL,
        pbd_pkg::REG_DEVICE_ID};
    localparam logic [11:0] SOFS [13] = '{12'h000, 12'h004, 12'h008, 12'h00C,
        12'h0B0, 12'h0B4, 12'h0B8, 12'h0BC, 12'h140, 12'h15C, 12'h164, 12'h168,
        12'h198};
    localparam pbd_pkg::pbd_reg_t SREG [13] = '{pbd_pkg::REG_GPIO_LO_IN,
        pbd_pkg::REG_GPIO_LO_OUT, pbd_pkg::REG_GPIO_LO_OE,
        pbd_pkg::REG_GPIO_LO_FUNC, pbd_pkg::REG_GPIO_HI_IN,
        pbd_pkg::REG_GPIO_HI_OUT, pbd_pkg::REG_GPIO_HI_OE,
        pbd_pkg::REG_GPIO_HI_FUNC, pbd_pkg::REG_SEC_PRIORITY,
        pbd_pkg::REG_SEC_PRIORITY, pbd_pkg::REG_SPUR_VECTOR,
        pbd_pkg::REG_VECTOR_BASE, pbd_pkg::REG_SOFT_IRQ};
    logic clk;
    logic srst;
    logic cregWrEn, cregSuper, dbgRdEn, dbgRdValid, accValid;
    logic decValid, decWrEn, decWrBlocked;
    logic [11:0] cregSel, dbgRdSel, decOffset;
    logic [31:0] cregWrData, dbgRdData, accAddr;
    logic [5:0] accAttr;
    logic [3:0] decIndex;
    logic [1:0] decLane;
    pbd_pkg::pbd_target_t decTarget;
    pbd_pkg::pbd_reg_t decReg;
    int nErrors;
    int cmpCount;

    pbd_core_model core_u (.clk, .cregWrEn, .cregSel, .cregWrData, .cregSuper,
        .dbgRdEn, .dbgRdSel, .accValid, .accAddr, .accAttr);

    pbd_peripheral_base_decoder dut_u (.clk, .srst, .cregWrEn, .cregSel,
        .cregWrData, .cregSuper, .dbgRdEn, .dbgRdSel, .dbgRdData, .dbgRdValid,
        .accValid, .accAddr, .accWrite(accAttr[5]), .accSuper(accAttr[4]),
        .accCode(accAttr[3]), .accIack(accAttr[2]),
        .accAltMaster(accAttr[1]), .sramHit(accAttr[0]), .decValid,
        .decTarget, .decReg, .decIndex, .decLane, .decOffset, .decWrEn,
        .decWrBlocked);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (nErrors == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic acc_chk(input logic [31:0] a, input logic [5:0] at,
            input pbd_pkg::pbd_target_t tgt, input pbd_pkg::pbd_reg_t rg);
        core_u.acc(a, at);
        chk(32'(decValid), 32'h1);
        chk(32'(decTarget), 32'(tgt));
        chk(32'(decReg), 32'(rg));
    endtask

    // write access; wr is the expected {decWrEn, decWrBlocked}
    task automatic wr_chk(input logic [31:0] a, input pbd_pkg::pbd_target_t t,
            input pbd_pkg::pbd_reg_t rg, input logic [1:0] wr);
        acc_chk(a, 6'h30, t, rg);
        chk(32'({decWrEn, decWrBlocked}), 32'(wr));
    endtask

    task automatic rd_back(input logic [11:0] sel, input logic [31:0] exp);
        core_u.dbg_read(sel);
        for (int i = 0; i < 4 && dbgRdValid !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (dbgRdValid !== 1'b1) begin
            nErrors++;
            tally_and_finish();
        end else begin
            chk(dbgRdData, exp);
        end
    endtask

    task automatic wr_pri(input logic [31:0] v);
        core_u.creg_write(pbd_pkg::CREG_PRIMARY, v, 1'b1);
    endtask

    task automatic wr_sec(input logic [31:0] v);
        core_u.creg_write(pbd_pkg::CREG_SECONDARY, v, 1'b1);
    endtask

    task automatic s_after_reset();
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        acc_chk(PRI | 32'h40, RD_SUP, EXT, NOREG);
        acc_chk(PRI | 32'h40, 6'h11, pbd_pkg::TGT_SRAM, NOREG);
    endtask

    task automatic s_base_regs();
        wr_pri(PRI | 32'h1);
        rd_back(pbd_pkg::CREG_PRIMARY, PRI | 32'h1);
        core_u.creg_write(pbd_pkg::CREG_PRIMARY, 32'hFFFF_FFFF, 1'b0);
        rd_back(pbd_pkg::CREG_PRIMARY, PRI | 32'h1);
        wr_pri(32'hFFFF_FFFF);
        rd_back(pbd_pkg::CREG_PRIMARY, pbd_pkg::PRI_WR_MASK);
        wr_sec(32'hFFFF_FFFF);
        rd_back(pbd_pkg::CREG_SECONDARY, pbd_pkg::SEC_WR_MASK);
        rd_back(12'hC0D, 32'h0);
        wr_pri(PRI | 32'h1);
        wr_sec(SEC | 32'h1);
    endtask

    task automatic s_offsets();
        foreach (POFS[i]) begin
            acc_chk(PRI|POFS[i], RD_SUP, PRIM, PREG[i]);
        end
        acc_chk(PRI | 32'h57, RD_SUP, PRIM, pbd_pkg::REG_IRQ_CTRL);
        chk(32'(decIndex), 32'hB);
        chk(32'({decLane, decOffset}), 32'h3057);
        foreach (SOFS[i]) begin
            acc_chk(SEC|SOFS[i], RD_SUP, SECN, SREG[i]);
        end
        acc_chk(SEC | 32'h15C, RD_SUP, SECN, SREG[9]);
        chk(32'(decIndex), 32'h7);
    endtask

    task automatic s_masks();
        logic [5:0] at;
        for (int b = 1; b <= 4; b++) begin
            at = {1'b0, b >= 3, ~b[0], 3'b000};
            wr_pri(PRI | 32'h1 | (32'h1 << b));
            acc_chk(PRI, at, EXT, NOREG);
            acc_chk(PRI, at ^ 6'h10, PRIM, RC);
            acc_chk(PRI, at | 6'h02, PRIM, RC);
        end
        wr_pri(PRI | 32'h21);
        acc_chk(PRI, 6'h14, EXT, NOREG);
        wr_pri(PRI | 32'h41);
        acc_chk(PRI, 6'h12, EXT, NOREG);
        acc_chk(PRI, 6'h14, PRIM, RC);
    endtask

    task automatic s_write_prot();
        wr_pri(PRI | 32'h101);
        wr_chk(PRI | 32'h40, PRIM, pbd_pkg::REG_IRQ_PENDING, 2'b01);
        wr_pri(PRI | 32'h1);
        wr_chk(PRI | 32'h40, PRIM, pbd_pkg::REG_IRQ_PENDING, 2'b10);
        wr_chk(PRI | 32'hAC, PRIM, pbd_pkg::REG_DEVICE_ID, 2'b01);
        wr_chk(SEC, SECN, SREG[0], 2'b01);
        wr_chk(SEC | 32'hB0, SECN, SREG[4], 2'b01);
        wr_chk(SEC | 32'h4, SECN, SREG[1], 2'b10);
    endtask

    task automatic s_priority();
        wr_sec(32'h1);
        acc_chk(PRI|32'h40, RD_SUP, PRIM, pbd_pkg::REG_IRQ_PENDING);
        acc_chk(32'h198, RD_SUP, SECN, pbd_pkg::REG_SOFT_IRQ);
        acc_chk(32'h2000_0198, RD_SUP, SECN, NOREG);
        wr_sec(SEC);
        acc_chk(SEC | 32'h198, RD_SUP, EXT, NOREG);
    endtask

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        nErrors = 0;
        cmpCount = 0;
        forever #2 clk = ~clk;
    end

    initial begin
        s_after_reset();
        s_base_regs();
        s_offsets();
        s_masks();
        s_write_prot();
        s_priority();
        s_after_reset();
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        tally_and_finish();
    end
endmodule
